// >>> rtl/board_glue_pkg.sv
// board_glue_pkg: constants, address map and carrier types for the board glue logic
// assumes one 100 MHz clock; all processor-side pins are synchronous to it

package board_glue_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RESTART_MS     = 500;
   localparam int RESTART_CYCLES = RESTART_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PROC_PERIOD_NS = 1000;
   localparam int PROC_CYCLES    = PROC_PERIOD_NS / CLK_PERIOD_NS;

   localparam logic [6:0] PHASE_LAST  = 7'(PROC_CYCLES - 1);
   localparam logic [6:0] PHI1_END    = 7'h2D;
   localparam logic [6:0] PHI2_START  = 7'h32;
   localparam logic [6:0] PHI2_END    = 7'h5F;
   localparam logic [6:0] MEM_HI_END  = 7'h32;

   // ----------------------------------------------------------------
   // on-board address map (partial decode)
   // ----------------------------------------------------------------
   localparam logic [15:0] RAM_MASK   = 16'hFC00;
   localparam logic [15:0] RAM_BASE   = 16'h0000;
   localparam logic [15:0] ROM_MASK   = 16'hE000;
   localparam logic [15:0] ROM_BASE   = 16'hE000;
   localparam logic [15:0] PORT_MASK  = 16'hF000;
   localparam logic [15:0] PORT_BASE  = 16'h8000;
   localparam int          PORT_CHIPS = 3;
   localparam int          PORT_LSB   = 2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic        rnw;
      logic        valid;
      logic        ba;
   } proc_bus_t;

   typedef struct packed {
      logic       ram;
      logic       rom;
      logic [2:0] port;
      logic       offboard;
   } mem_sel_t;

   typedef struct packed {
      logic phi1;
      logic phi2;
      logic dataBusGate;
      logic memClk;
   } clk_out_t;

   typedef enum logic [1:0] {
      RF_IDLE = 2'b01,
      RF_HOLD = 2'b10
   } refresh_state_t;

   localparam clk_out_t CLK_OUT_RESET = '{phi1: 1'b1, phi2: 1'b0, dataBusGate: 1'b0,
                                          memClk: 1'b1};
   localparam mem_sel_t SEL_RESET     = '{ram: 1'b0, rom: 1'b0, port: 3'h0, offboard: 1'b0};

   function automatic logic inRegion(input logic [15:0] a, input logic [15:0] mask,
                                     input logic [15:0] base);
      return (a & mask) == base;
   endfunction : inRegion

endpackage : board_glue_pkg

// >>> rtl/restart_gen.sv
// restart_gen: power-on and bus-requested restart timer
// assumes rstN is already synchronised; extResetReqN is synchronous to clk
`timescale 1ns/1ps

module restart_gen #(
   parameter int HOLD_CYCLES = board_glue_pkg::RESTART_CYCLES
) (
   input  wire logic clk,
   input  wire logic rstN,
   input  wire logic extResetReqN,
   output logic      resetN_r
);
   import board_glue_pkg::*;

   logic [31:0] count_r;

   // a bus request restarts the full delay, like power-on
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_r  <= 32'h0;
         resetN_r <= 1'b0;
      end else if (!extResetReqN) begin
         count_r  <= 32'h0;
         resetN_r <= 1'b0;
      end else if (!resetN_r) begin
         if (count_r == 32'(HOLD_CYCLES - 1)) begin
            resetN_r <= 1'b1;
         end else begin
            count_r <= count_r + 32'h1;
         end
      end
   end

endmodule : restart_gen

// >>> rtl/addr_decode.sv
// addr_decode: partial decode of the processor address into on-board selects
// assumes address is stable while valid address strobe is high
`timescale 1ns/1ps

module addr_decode (
   input  wire logic [15:0]           addr,
   input  wire logic                  valid,
   output board_glue_pkg::mem_sel_t   sel
);
   import board_glue_pkg::*;

   logic anyPort;
   assign anyPort = inRegion(addr, PORT_MASK, PORT_BASE);

   assign sel.ram = valid && inRegion(addr, RAM_MASK, RAM_BASE);
   assign sel.rom = valid && inRegion(addr, ROM_MASK, ROM_BASE);

   // address bits 11:4 and 1:0 are ignored, so each chip shows up many times
   genvar g;
   generate
      for (g = 0; g < PORT_CHIPS; g++) begin : g_port
         assign sel.port[g] = valid && anyPort && (addr[PORT_LSB +: 2] == 2'(g));
      end
   endgenerate

   assign sel.offboard = valid && !(sel.ram || sel.rom || (|sel.port));

endmodule : addr_decode

// >>> rtl/board_glue.sv
// board_glue: restart, two-phase clocks, refresh hold, data buffer and address bus control
// assumes processor pins are synchronous to clk; tri-state drivers live outside
`timescale 1ns/1ps

module board_glue #(
   parameter int RESTART_CYCLES_P = board_glue_pkg::RESTART_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      extResetReqN,
   input  wire board_glue_pkg::proc_bus_t procBus,
   input  wire logic                      runStop,
   input  wire logic                      refreshRequestN,
   input  wire logic                      debugSel,
   input  wire logic                      debugUserValid,
   input  wire logic [7:0]                procWrData,
   input  wire logic [7:0]                extDataIn,
   output logic                           procResetN,
   output logic                           portChipResetN,
   output board_glue_pkg::clk_out_t       clocks,
   output logic                           clockHoldN,
   output logic                           refreshGrant,
   output logic                           inboundBufferEnN,
   output logic                           outboundBufferEn,
   output board_glue_pkg::mem_sel_t       chipSel,
   output logic [15:0]                    addrOut,
   output logic                           addrOe,
   output logic                           validAddressStrobe,
   output logic                           userValidAddress,
   output logic [7:0]                     extDataOut,
   output logic                           extDataOe,
   output logic [7:0]                     procRdData
);
   import board_glue_pkg::*;

   // ----------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------
   logic rstMeta_r;
   logic rstN;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstN      <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstN      <= rstMeta_r;
      end
   end

   // ----------------------------------------------------------------
   // restart generator
   // ----------------------------------------------------------------
   logic restartN_r;

   restart_gen #(
      .HOLD_CYCLES (RESTART_CYCLES_P)
   ) u_restart (
      .clk          (clk),
      .rstN         (rstN),
      .extResetReqN (extResetReqN),
      .resetN_r     (restartN_r)
   );

   // one flop feeds the processor and every port chip
   assign procResetN     = restartN_r;
   assign portChipResetN = restartN_r;

   // ----------------------------------------------------------------
   // clock generator
   // ----------------------------------------------------------------
   refresh_state_t rfState_r;
   refresh_state_t rfState_nxt;
   logic [6:0]     phaseCnt_r;
   logic [6:0]     phaseCnt_nxt;
   logic [6:0]     memCnt_r;
   logic [6:0]     memCnt_nxt;
   clk_out_t       clocks_r;
   clk_out_t       clocks_nxt;
   logic           frozen;
   logic           memPulse;

   // the freeze waits for phase zero, so a hold never cuts phase two short
   assign frozen   = (rfState_r == RF_HOLD) && (phaseCnt_r == 7'h00);
   assign memPulse = (memCnt_r == 7'h00);

   always_comb begin
      if (frozen) begin
         phaseCnt_nxt = phaseCnt_r;
      end else if (phaseCnt_r == PHASE_LAST) begin
         phaseCnt_nxt = 7'h00;
      end else begin
         phaseCnt_nxt = phaseCnt_r + 7'h01;
      end
      if (memCnt_r == PHASE_LAST) begin
         memCnt_nxt = 7'h00;
      end else begin
         memCnt_nxt = memCnt_r + 7'h01;
      end
      // gaps between the two windows keep the phases from overlapping
      clocks_nxt.phi1        = phaseCnt_nxt < PHI1_END;
      clocks_nxt.phi2        = (phaseCnt_nxt >= PHI2_START) && (phaseCnt_nxt < PHI2_END);
      clocks_nxt.dataBusGate = !clocks_nxt.phi1;
      clocks_nxt.memClk      = memCnt_nxt < MEM_HI_END;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         phaseCnt_r <= 7'h00;
         memCnt_r   <= 7'h00;
         clocks_r   <= CLK_OUT_RESET;
      end else begin
         phaseCnt_r <= phaseCnt_nxt;
         memCnt_r   <= memCnt_nxt;
         clocks_r   <= clocks_nxt;
      end
   end

   assign clocks = clocks_r;

   // ----------------------------------------------------------------
   // refresh hold
   // ----------------------------------------------------------------
   always_comb begin
      rfState_nxt = rfState_r;
      unique case (rfState_r)
         RF_IDLE: begin
            if (memPulse && !refreshRequestN) begin
               rfState_nxt = RF_HOLD;
            end
         end
         RF_HOLD: begin
            if (refreshRequestN) begin
               rfState_nxt = RF_IDLE;
            end
         end
         default: begin
            rfState_nxt = RF_IDLE;
         end
      endcase
   end

   logic holdN_r;
   logic grant_r;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rfState_r <= RF_IDLE;
         holdN_r   <= 1'b1;
         grant_r   <= 1'b0;
      end else begin
         rfState_r <= rfState_nxt;
         holdN_r   <= rfState_nxt != RF_HOLD;
         grant_r   <= rfState_nxt == RF_HOLD;
      end
   end

   assign clockHoldN   = holdN_r;
   assign refreshGrant = grant_r;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   mem_sel_t selNow;
   mem_sel_t sel_r;

   addr_decode u_decode (
      .addr  (procBus.addr),
      .valid (procBus.valid),
      .sel   (selNow)
   );

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sel_r <= SEL_RESET;
      end else begin
         sel_r <= selNow;
      end
   end

   assign chipSel = sel_r;

   // ----------------------------------------------------------------
   // read/write buffer control
   // ----------------------------------------------------------------
   logic phi2Rise;
   logic phi2Fall;
   logic gateRise;
   logic gateFall;
   logic inN_r;
   logic out_r;

   assign phi2Rise = clocks_nxt.phi2 && !clocks_r.phi2;
   assign phi2Fall = !clocks_nxt.phi2 && clocks_r.phi2;
   assign gateRise = clocks_nxt.dataBusGate && !clocks_r.dataBusGate;
   assign gateFall = !clocks_nxt.dataBusGate && clocks_r.dataBusGate;

   // inbound closes at phase-two fall, so transfers stay inside phase two
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         inN_r <= 1'b1;
      end else if (phi2Rise && procBus.rnw && selNow.offboard && !out_r) begin
         inN_r <= 1'b0;
      end else if (phi2Fall) begin
         inN_r <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         out_r <= 1'b0;
      end else if (gateRise && !procBus.rnw && !procBus.ba && inN_r) begin
         out_r <= 1'b1;
      end else if (gateFall) begin
         out_r <= 1'b0;
      end
   end

   assign inboundBufferEnN = inN_r;
   assign outboundBufferEn = out_r;

   logic [7:0] wrData_r;
   logic [7:0] rdData_r;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrData_r <= 8'h00;
      end else begin
         wrData_r <= procWrData;
      end
   end

   // read data only follows the external bus while the input buffers are open
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdData_r <= 8'h00;
      end else if (!inN_r) begin
         rdData_r <= extDataIn;
      end
   end

   assign extDataOut = wrData_r;
   assign extDataOe  = out_r;
   assign procRdData = rdData_r;

   // ----------------------------------------------------------------
   // external address bus and valid strobes
   // ----------------------------------------------------------------
   logic [15:0] addr_r;
   logic        addrOe_r;
   logic        strobe_r;
   logic        userVal_r;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         addr_r   <= 16'h0000;
         addrOe_r <= 1'b0;
      end else begin
         addr_r   <= procBus.addr;
         addrOe_r <= !procBus.ba || runStop;
      end
   end

   // jumper low means no debug unit: both strobes carry the same value
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         strobe_r  <= 1'b0;
         userVal_r <= 1'b0;
      end else begin
         strobe_r  <= procBus.valid;
         userVal_r <= debugSel ? debugUserValid : procBus.valid;
      end
   end

   assign addrOut            = addr_r;
   assign addrOe             = addrOe_r;
   assign validAddressStrobe = strobe_r;
   assign userValidAddress   = userVal_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstN);

   logic [31:0] lowRun_r;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         lowRun_r <= 32'h0;
      end else if (!extResetReqN || restartN_r) begin
         lowRun_r <= 32'h0;
      end else begin
         lowRun_r <= lowRun_r + 32'h1;
      end
   end

   chk_restart_length: assert property (
      $rose(procResetN) |-> lowRun_r == 32'(RESTART_CYCLES_P))
      else $error("restart released after the wrong number of cycles");

   chk_bus_reset_req: assert property (
      !extResetReqN |=> !procResetN [*2])
      else $error("bus reset request did not hold reset low");

   chk_port_reset_tie: assert property (
      portChipResetN == procResetN)
      else $error("port chip reset differs from processor reset");

   chk_phase_overlap: assert property (
      !(clocks.phi1 && clocks.phi2) and ($fell(clocks.phi1) |-> !clocks.phi2 [*5]))
      else $error("processor clock phases overlap");

   chk_gate_inverse: assert property (
      clocks.dataBusGate == !clocks.phi1)
      else $error("data bus gate is not the inverse of phase one");

   chk_inbound_window: assert property (
      !inboundBufferEnN |-> clocks.phi2)
      else $error("inbound buffers open outside phase two");

   chk_refresh_grant: assert property (
      (memPulse && !refreshRequestN && rfState_r == RF_IDLE)
      |=> !clockHoldN && refreshGrant)
      else $error("refresh request not granted on memory clock pulse");

   chk_freeze_level: assert property (
      $fell(clockHoldN)
      |-> ##[0:100] (clockHoldN || (clocks.phi1 && !clocks.phi2 && phaseCnt_r == 7'h00)))
      else $error("processor clocks did not freeze under hold");

   chk_memclk_runs: assert property (
      $rose(clocks.memClk) |-> ##100 $rose(clocks.memClk))
      else $error("memory clock stopped");

   chk_hold_release: assert property (
      (!clockHoldN && refreshRequestN) |=> clockHoldN && !refreshGrant)
      else $error("clock hold not released after refresh request rose");

   chk_inbound_open: assert property (
      (phi2Rise && procBus.rnw && selNow.offboard) |=> !inboundBufferEnN)
      else $error("inbound buffers not opened on off-board read");

   chk_outbound_open: assert property (
      (gateRise && !procBus.rnw && !procBus.ba) |=> outboundBufferEn)
      else $error("outbound buffers not opened on write");

   chk_offboard_flag: assert property (
      (procBus.valid && inRegion(procBus.addr, RAM_MASK, RAM_BASE))
      |=> chipSel.ram && !chipSel.offboard)
      else $error("on-board address flagged as off-board");

   chk_addr_enable: assert property (
      (!procBus.ba || runStop) |=> addrOe)
      else $error("address drivers not enabled");

   chk_user_valid: assert property (
      !debugSel |=> userValidAddress == $past(procBus.valid))
      else $error("user valid address does not follow valid strobe");

   chk_buffer_exclusive: assert property (
      !(outboundBufferEn && !inboundBufferEnN))
      else $error("both data buffer directions enabled");

   cov_refresh_freeze: cover property (!clockHoldN && frozen ##1 clockHoldN);
   cov_offboard_read:  cover property ($fell(inboundBufferEnN));
   cov_offboard_write: cover property ($rose(outboundBufferEn));
   cov_restart_done:   cover property ($rose(procResetN));

endmodule : board_glue

// >>> testbench/mem_module_model.sv
// mem_module_model: dynamic memory module asking the board for a refresh slot
// assumes start is a one-cycle pulse from the bench and memClk comes from the glue
`timescale 1ns/1ps

module mem_module_model #(
   parameter int REFRESH_PULSES = 4
) (
   input  wire logic clk,
   input  wire logic memClk,
   input  wire logic refreshGrant,
   input  wire logic start,
   output logic      refreshRequestN,
   output logic      busy
);
   // ----------------------------------------------------------------
   // refresh handshake
   // ----------------------------------------------------------------
   // larger REFRESH_PULSES gives a slow module, 1 a prompt one
   initial begin
      refreshRequestN = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk iff start === 1'b1);
         #1;
         busy = 1'b1;
         refreshRequestN = 1'b0;
         while (refreshGrant !== 1'b1) begin
            @(posedge clk);
         end
         repeat (REFRESH_PULSES) @(posedge memClk);
         @(posedge clk);
         #1;
         refreshRequestN = 1'b1;
         busy = 1'b0;
      end
   end
endmodule : mem_module_model

// >>> testbench/testbench.sv
// testbench: self-checking bench for board_glue with a refresh-requesting memory module
// assumes a short restart count; inputs change 1 ns after each rising clock edge
`timescale 1ns/1ps

`define CHK(what, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
   end end

module testbench;
   import board_glue_pkg::*;

   localparam int RESTART = 20;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic       clk, nrst, extResetReqN, runStop, refreshRequestN, debugSel, debugUserValid;
   logic       procResetN, portChipResetN, clockHoldN, refreshGrant, inboundBufferEnN;
   logic       outboundBufferEn, addrOe, validAddressStrobe, userValidAddress, extDataOe;
   logic       refreshStart, modelBusy;
   logic [7:0] procWrData, extDataIn, extDataOut, procRdData;
   logic [15:0] addrOut;
   proc_bus_t  procBus;
   clk_out_t   clocks;
   mem_sel_t   chipSel;
   int         fail_count = 0;
   int         checked = 0;

   board_glue #(.RESTART_CYCLES_P(RESTART)) board_glue_i (.clk(clk), .nrst(nrst),
      .extResetReqN(extResetReqN), .procBus(procBus), .runStop(runStop),
      .refreshRequestN(refreshRequestN), .debugSel(debugSel), .debugUserValid(debugUserValid),
      .procWrData(procWrData), .extDataIn(extDataIn), .procResetN(procResetN),
      .portChipResetN(portChipResetN), .clocks(clocks), .clockHoldN(clockHoldN),
      .refreshGrant(refreshGrant), .inboundBufferEnN(inboundBufferEnN),
      .outboundBufferEn(outboundBufferEn), .chipSel(chipSel), .addrOut(addrOut),
      .addrOe(addrOe), .validAddressStrobe(validAddressStrobe),
      .userValidAddress(userValidAddress), .extDataOut(extDataOut), .extDataOe(extDataOe),
      .procRdData(procRdData));

   mem_module_model #(.REFRESH_PULSES(4)) mem_module_model_i (.clk(clk),
      .memClk(clocks.memClk), .refreshGrant(refreshGrant), .start(refreshStart),
      .refreshRequestN(refreshRequestN), .busy(modelBusy));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   // which: 0 waits for phi2 rise, 1 for data bus gate rise
   task automatic wait_rise(input int which);
      logic prev, cur;
      int   n;
      prev = 1'b1;
      for (n = 0; n < 300; n++) begin
         tick();
         cur = (which == 0) ? clocks.phi2 : clocks.dataBusGate;
         if (cur === 1'b1 && prev === 1'b0) break;
         prev = cur;
      end
      `CHK("edge seen", 1'b1, n < 300)
   endtask : wait_rise

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_restart();
      int n;
      for (n = 0; n < 40 && procResetN !== 1'b1; n++) begin
         `CHK("port chip reset", 1'b0, portChipResetN)
         tick();
      end
      `CHK("power-on span", 1'b1, n >= RESTART && n <= RESTART + 4)
      extResetReqN = 1'b0;
      tick();
      extResetReqN = 1'b1;
      tick();
      `CHK("bus reset", 1'b0, procResetN)
      `CHK("bus reset ports", 1'b0, portChipResetN)
      for (n = 0; n < 40 && procResetN !== 1'b1; n++) tick();
      `CHK("bus reset span", 1'b1, n >= RESTART - 3 && n <= RESTART + 2)
      $display("test_restart done");
   endtask : test_restart

   task automatic test_clocks();
      int hi1, hi2, both, gateBad, memHi;
      hi1 = 0; hi2 = 0; both = 0; gateBad = 0; memHi = 0;
      // any 200 samples span exactly two processor periods
      repeat (200) begin
         tick();
         hi1 += int'(clocks.phi1 === 1'b1);
         hi2 += int'(clocks.phi2 === 1'b1);
         both += int'(clocks.phi1 !== 1'b0 && clocks.phi2 !== 1'b0);
         gateBad += int'(clocks.dataBusGate !== ~clocks.phi1);
         memHi += int'(clocks.memClk === 1'b1);
      end
      `CHK("phi1 high", 90, hi1)
      `CHK("phi2 high", 90, hi2)
      `CHK("overlap", 0, both)
      `CHK("gate inverse", 0, gateBad)
      `CHK("mem clk high", 100, memHi)
      $display("test_clocks done");
   endtask : test_clocks

   task automatic test_decode();
      logic [15:0] a [7] = '{16'h0010, 16'hE100, 16'h8000, 16'h8004, 16'h8008, 16'h800C, 16'h4000};
      logic [5:0]  e [7] = '{6'h20, 6'h10, 6'h02, 6'h04, 6'h08, 6'h01, 6'h01};
      for (int i = 0; i < 7; i++) begin
         procBus = '{addr: a[i], rnw: 1'b0, valid: 1'b1, ba: 1'b1};
         tick();
         tick();
         `CHK("chip select", e[i], chipSel)
      end
      procBus.valid = 1'b0;
      tick();
      tick();
      `CHK("no strobe no select", 6'h00, chipSel)
      $display("test_decode done");
   endtask : test_decode

   task automatic test_read();
      int n;
      procBus = '{addr: 16'h4000, rnw: 1'b1, valid: 1'b1, ba: 1'b0};
      extDataIn = 8'hA5;
      wait_rise(0);
      `CHK("inbound open", 1'b0, inboundBufferEnN)
      `CHK("outbound shut", 1'b0, outboundBufferEn)
      tick();
      tick();
      `CHK("read data", 8'hA5, procRdData)
      for (n = 0; n < 60 && clocks.phi2 === 1'b1; n++) begin
         `CHK("inbound in phi2", 1'b0, inboundBufferEnN)
         tick();
      end
      `CHK("inbound closes", 1'b1, inboundBufferEnN)
      procBus.addr = 16'h0010;
      wait_rise(0);
      `CHK("on-board read", 1'b1, inboundBufferEnN)
      $display("test_read done");
   endtask : test_read

   task automatic test_write();
      procBus = '{addr: 16'h4000, rnw: 1'b0, valid: 1'b1, ba: 1'b0};
      procWrData = 8'h3C;
      wait_rise(1);
      `CHK("outbound open", 1'b1, outboundBufferEn)
      `CHK("data oe", 1'b1, extDataOe)
      `CHK("write data", 8'h3C, extDataOut)
      `CHK("inbound shut", 1'b1, inboundBufferEnN)
      procBus.ba = 1'b1;
      wait_rise(1);
      `CHK("bus available write", 1'b0, outboundBufferEn)
      $display("test_write done");
   endtask : test_write

   task automatic test_refresh();
      int   n, rises;
      logic prevMem;
      refreshStart = 1'b1;
      tick();
      refreshStart = 1'b0;
      for (n = 0; n < 110 && refreshGrant !== 1'b1; n++) tick();
      `CHK("grant", 1'b1, refreshGrant)
      `CHK("module busy", 1'b1, modelBusy)
      `CHK("clock hold", 1'b0, clockHoldN)
      // freeze waits for the start of the next processor period
      repeat (101) tick();
      rises = 0;
      prevMem = clocks.memClk;
      for (n = 0; n < 1000 && refreshGrant === 1'b1; n++) begin
         `CHK("phi1 frozen", 1'b1, clocks.phi1)
         `CHK("phi2 frozen", 1'b0, clocks.phi2)
         rises += int'(clocks.memClk === 1'b1 && prevMem === 1'b0);
         prevMem = clocks.memClk;
         tick();
      end
      `CHK("mem clk runs", 1'b1, rises >= 2)
      `CHK("hold released", 1'b1, clockHoldN)
      `CHK("module done", 1'b0, modelBusy)
      for (n = 0; n < 50 && clocks.phi1 === 1'b1; n++) tick();
      `CHK("phases resume", 1'b1, n < 50)
      $display("test_refresh done");
   endtask : test_refresh

   task automatic test_addr();
      for (logic [2:0] i = 0; i < 4; i++) begin
         procBus.ba = i[1];
         runStop = i[0];
         procBus.addr = {8'h12, 6'h00, i[1:0]};
         tick();
         tick();
         `CHK("address enable", ~i[1] | i[0], addrOe)
         `CHK("address out", {8'h12, 6'h00, i[1:0]}, addrOut)
      end
      debugSel = 1'b0;
      procBus.valid = 1'b1;
      tick();
      tick();
      `CHK("valid strobe", 1'b1, validAddressStrobe)
      `CHK("user valid high", 1'b1, userValidAddress)
      debugSel = 1'b1;
      debugUserValid = 1'b1;
      procBus.valid = 1'b0;
      tick();
      tick();
      `CHK("debug user valid", 1'b1, userValidAddress)
      `CHK("strobe apart", 1'b0, validAddressStrobe)
      debugUserValid = 1'b0;
      tick();
      tick();
      `CHK("debug user low", 1'b0, userValidAddress)
      $display("test_addr done");
   endtask : test_addr

   // ----------------------------------------------------------------
   // sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      extResetReqN = 1'b1;
      procBus = '0;
      runStop = 1'b1;
      refreshStart = 1'b0;
      debugSel = 1'b0;
      debugUserValid = 1'b0;
      procWrData = 8'h00;
      extDataIn = 8'h00;
      repeat (16) @(posedge clk);
      #1;
      nrst = 1'b1;
      test_restart();
      test_clocks();
      test_decode();
      test_read();
      test_write();
      test_refresh();
      test_addr();
      test_done();
   end

   // the whole run needs about 1200 cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done();
   end
endmodule : testbench
